// ### ams_pkg.sv
// Constants and types shared by the mode switch register bank.
// Assumes a single 100 MHz clock domain; pins are synchronised inside the register bank.
package ams_pkg;

  // ********************
  // Register offsets
  // ********************
  localparam logic [7:0] ADDR_GEN      = 8'h0A;
  localparam logic [7:0] ADDR_EQ01     = 8'h10;
  localparam logic [7:0] ADDR_EQ23     = 8'h11;
  localparam logic [7:0] ADDR_SNOOP    = 8'h12;
  localparam logic [7:0] ADDR_LANE_OFF = 8'h13;

  // ********************
  // Field positions
  // ********************
  localparam int GEN_SWAP_BIT   = 5;
  localparam int GEN_EQSRC_BIT  = 4;
  localparam int GEN_FORCE_BIT  = 3;
  localparam int GEN_FLIP_BIT   = 2;
  localparam int GEN_CFG_HI_BIT = 1;
  localparam int OFF_SNOOP_BIT  = 7;

  // ********************
  // Reset values and encodings
  // ********************
  localparam logic [5:0]  GEN_RESET   = 6'h01;
  localparam logic [15:0] EQ_RESET    = 16'h0000;
  localparam logic [1:0]  CFG_OFF     = 2'h0;
  localparam logic [1:0]  CFG_USB     = 2'h1;
  localparam logic [1:0]  CFG_DP4     = 2'h2;
  localparam logic [1:0]  CFG_DP2_USB = 2'h3;
  localparam logic [1:0]  PWR_ON      = 2'h1;
  localparam logic [19:0] AUX_PWR_ADDR = 20'h0_0600;
  localparam logic [19:0] AUX_CNT_ADDR = 20'h0_0101;
  localparam logic [6:0]  I2C_ADDR_DEF = 7'h44;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
  } ams_i2c_st_t;

endpackage

// ### ams_sync.sv
// Two-flop synchroniser, one stage pair per bit.
// Assumes inputs are asynchronous to mclk.
`timescale 1ns/1ns
module ams_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
  } ams_sync_t;

  ams_sync_t r_reg;
  ams_sync_t r_next;

  always_comb
  begin
    r_next     = r_reg;
    r_next.ff1 = d;
    r_next.ff2 = r_reg.ff1;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  // Only the second stage is seen outside
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      assign q[g] = r_reg.ff2[g];
    end
  endgenerate

endmodule

// ### ams_ctrl_regs.sv
// Control and status register bank of the mode switch, reached over I2C.
// Assumes AUX snoop inputs are on mclk; pins are async and synchronised here.
//
// Functional notes
// - Lane config: 00 all off, 01 USB only (reset), 10 four DP, 11 two DP+USB.
// - General register resets to 01h; top two bits read zero, ignore writes.
// - Bit 5 moves hot-plug input to its alternate pin when set.
// - Bit 4 picks equalizer source: straps when 0, registers when 1.
// - Bit 3 forces internal hot-plug status high; else follows the pin.
// - Four-bit EQ per DP lane: 10h lanes 0/1, 11h lanes 2/3, reset 0.
// - With straps as source, EQ fields read back the strap level.
// - With registers as source, written EQ values set lane equalization.
// - Bits 6:5 of 12h capture AUX writes to 600h; read-only, bit 7 zero.
// - Snoop enabled: captured power state switches DP lanes on or off.
// - Bits 4:0 of 12h capture AUX writes to 101h; read-only, reset 0.
// - Snoop enabled: only lanes within captured lane count run.
// - Snoop disabled: lanes follow per-lane off bits only.
// - Captured power state clears when upper config bit falls.
// - Captured lane count clears when upper config bit falls.
// - Reads run sequentially from last sub-address, advancing per byte.
// - Per-lane off bits in 13h act only while snoop disabled.
`timescale 1ns/1ns
module ams_ctrl_regs
  import ams_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = I2C_ADDR_DEF  // Arbitrary default
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // I2C pins
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Board pins
  input  wire logic        hotplug_input_pin,
  input  wire logic        hotplug_input_alt_pin,
  input  wire logic [1:0]  display_eq_straps,
  // AUX snoop from sideband monitor
  input  wire logic        aux_wr_valid,
  input  wire logic [19:0] aux_wr_addr,
  input  wire logic [7:0]  aux_wr_data,
  // Switch controls
  output logic [1:0]       lane_config_select,
  output logic             orientation_select,
  output logic             hotplug_status,
  output logic [15:0]      lane_eq_level,
  output logic [3:0]       lane_enable
);

  // ********************
  // State
  // ********************
  typedef struct packed {
    ams_i2c_st_t st;
    logic [3:0]  cnt;
    logic [7:0]  shreg;
    logic [7:0]  ptr;
    logic        rw;
    logic        have_sub;
    logic        acked;
    logic        scl_q;
    logic        sda_q;
    logic        sda_o;
    logic        sda_oe;
    logic [5:0]  gen;
    logic [15:0] eq;
    logic [1:0]  pwr;
    logic [4:0]  lcnt;
    logic        snoop_dis;
    logic [3:0]  off;
    logic [3:0]  lane_en;
    logic        hp;
  } ams_state_t;

  ams_state_t r_reg;
  ams_state_t r_next;

  logic [5:0] sync_q;
  logic       scl_s;
  logic       sda_s;
  logic       hp_def_s;
  logic       hp_alt_s;
  logic [1:0] strap_s;
  logic [3:0] strap_level;
  logic [3:0] snoop_mask;
  logic [7:0] rd_byte;

  // ********************
  // Pin synchronisers
  // ********************
  ams_sync #(.W(6)) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     ({scl, sda_in, hotplug_input_pin, hotplug_input_alt_pin, display_eq_straps}),
    .q     (sync_q)
  );

  assign {scl_s, sda_s, hp_def_s, hp_alt_s, strap_s} = sync_q;

  // Strap level spread over the 0..12 code range in steps of 4
  assign strap_level = {strap_s, 2'b00};

  function automatic logic [3:0] cnt_mask(input logic [4:0] c);
    cnt_mask = {{2{c >= 5'h04}}, c >= 5'h02, c >= 5'h01};
  endfunction

  function automatic logic [3:0] cfg_mask(input logic [1:0] cfg);
    case (cfg)
      CFG_DP4:     cfg_mask = 4'hF;
      CFG_DP2_USB: cfg_mask = 4'h3;
      default:     cfg_mask = 4'h0;
    endcase
  endfunction

  // Lanes run only when sink is powered, config allows them and count names them
  assign snoop_mask = (r_reg.pwr == PWR_ON) ? (cfg_mask(r_reg.gen[1:0]) & cnt_mask(r_reg.lcnt)) : 4'h0;

  // ********************
  // Register read mux
  // ********************
  always_comb
  begin
    case (r_reg.ptr)
      ADDR_GEN:      rd_byte = {2'b00, r_reg.gen};
      ADDR_EQ01:     rd_byte = r_reg.eq[7:0];
      ADDR_EQ23:     rd_byte = r_reg.eq[15:8];
      ADDR_SNOOP:    rd_byte = {1'b0, r_reg.pwr, r_reg.lcnt};
      ADDR_LANE_OFF: rd_byte = {r_reg.snoop_dis, 3'b000, r_reg.off};
      default:       rd_byte = 8'h00;
    endcase
  end

  // ********************
  // Next state
  // ********************
  always_comb
  begin
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic wr;
    start   = 1'b0;
    stop    = 1'b0;
    rise    = 1'b0;
    fall    = 1'b0;
    wr      = 1'b0;
    r_next  = r_reg;
    start   = r_reg.scl_q & scl_s & r_reg.sda_q & ~sda_s;
    stop    = r_reg.scl_q & scl_s & ~r_reg.sda_q & sda_s;
    rise    = ~r_reg.scl_q & scl_s;
    fall    = r_reg.scl_q & ~scl_s;
    r_next.scl_q = scl_s;
    r_next.sda_q = sda_s;
    r_next.sda_o = 1'b0;

    // I2C target; repeated start restarts the address phase
    if (start)
    begin
      r_next.st       = ST_ADDR;
      r_next.cnt      = 4'h0;
      r_next.have_sub = 1'b0;
      r_next.sda_oe   = 1'b0;
    end
    else if (stop)
    begin
      r_next.st     = ST_IDLE;
      r_next.sda_oe = 1'b0;
    end
    else if (rise)
    begin
      case (r_reg.st)
        ST_ADDR, ST_WDATA:
        begin
          r_next.shreg = {r_reg.shreg[6:0], sda_s};
          r_next.cnt   = r_reg.cnt + 4'h1;
        end
        ST_RDATA:
          r_next.cnt = r_reg.cnt + 4'h1;
        ST_RACK:
        begin
          r_next.acked = ~sda_s;
          r_next.ptr   = r_reg.ptr + 8'h01;
        end
        default:
          r_next.cnt = r_reg.cnt;
      endcase
    end
    else if (fall)
    begin
      case (r_reg.st)
        ST_ADDR:
        begin
          if (r_reg.cnt == 4'h8)
          begin
            if (r_reg.shreg[7:1] == DEV_ADDR)
            begin
              r_next.rw     = r_reg.shreg[0];
              r_next.sda_oe = 1'b1;
              r_next.st     = ST_AACK;
            end
            else
              r_next.st = ST_IDLE;
          end
        end
        ST_AACK:
        begin
          r_next.cnt = 4'h0;
          if (r_reg.rw)
          begin
            // Read starts at the last sub-address or one past the last byte read or written
            r_next.shreg  = rd_byte;
            r_next.sda_oe = ~rd_byte[7];
            r_next.st     = ST_RDATA;
          end
          else
          begin
            r_next.sda_oe = 1'b0;
            r_next.st     = ST_WDATA;
          end
        end
        ST_WDATA:
        begin
          if (r_reg.cnt == 4'h8)
          begin
            r_next.sda_oe = 1'b1;
            r_next.st     = ST_WACK;
            if (!r_reg.have_sub)
            begin
              r_next.ptr      = r_reg.shreg;
              r_next.have_sub = 1'b1;
            end
            else
            begin
              wr         = 1'b1;
              r_next.ptr = r_reg.ptr + 8'h01;
            end
          end
        end
        ST_WACK:
        begin
          r_next.sda_oe = 1'b0;
          r_next.cnt    = 4'h0;
          r_next.st     = ST_WDATA;
        end
        ST_RDATA:
        begin
          if (r_reg.cnt == 4'h8)
          begin
            r_next.sda_oe = 1'b0;
            r_next.st     = ST_RACK;
          end
          else
            r_next.sda_oe = ~r_reg.shreg[3'h7 - r_reg.cnt[2:0]];
        end
        ST_RACK:
        begin
          r_next.cnt = 4'h0;
          if (r_reg.acked)
          begin
            r_next.shreg  = rd_byte;
            r_next.sda_oe = ~rd_byte[7];
            r_next.st     = ST_RDATA;
          end
          else
          begin
            r_next.sda_oe = 1'b0;
            r_next.st     = ST_IDLE;
          end
        end
        default:
          r_next.st = ST_IDLE;
      endcase
    end

    // Register writes; read-only fields take no write
    if (wr)
    begin
      case (r_reg.ptr)
        ADDR_GEN:  r_next.gen = r_reg.shreg[5:0];
        ADDR_EQ01: r_next.eq[7:0] = r_reg.shreg;
        ADDR_EQ23: r_next.eq[15:8] = r_reg.shreg;
        ADDR_LANE_OFF:
        begin
          r_next.snoop_dis = r_reg.shreg[OFF_SNOOP_BIT];
          r_next.off       = r_reg.shreg[3:0];
        end
        default:
          r_next.gen = r_reg.gen;
      endcase
    end

    // Strap source overwrites any software value every cycle
    if (!r_reg.gen[GEN_EQSRC_BIT])
      r_next.eq = {4{strap_level}};

    // Capture beats the clear so a snoop in the same cycle is kept
    if (r_reg.gen[GEN_CFG_HI_BIT] && !r_next.gen[GEN_CFG_HI_BIT])
    begin
      r_next.pwr  = 2'b00;
      r_next.lcnt = 5'h00;
    end
    if (aux_wr_valid && aux_wr_addr == AUX_PWR_ADDR)
      r_next.pwr = aux_wr_data[1:0];
    if (aux_wr_valid && aux_wr_addr == AUX_CNT_ADDR)
      r_next.lcnt = aux_wr_data[4:0];

    // Lane enables
    if (r_reg.snoop_dis)
      r_next.lane_en = ~r_reg.off;
    else
      r_next.lane_en = snoop_mask;

    // Hot-plug pin choice, then force
    r_next.hp = r_reg.gen[GEN_FORCE_BIT] | (r_reg.gen[GEN_SWAP_BIT] ? hp_alt_s : hp_def_s);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_reg       <= '0;
      r_reg.st    <= ST_IDLE;
      r_reg.scl_q <= 1'b1;
      r_reg.sda_q <= 1'b1;
      r_reg.gen   <= GEN_RESET;
      r_reg.eq    <= EQ_RESET;
    end
    else
      r_reg <= r_next;
  end

  // ********************
  // Outputs
  // ********************
  assign sda_out            = r_reg.sda_o;
  assign sda_oe             = r_reg.sda_oe;
  assign lane_config_select = r_reg.gen[1:0];
  assign orientation_select = r_reg.gen[GEN_FLIP_BIT];
  assign hotplug_status     = r_reg.hp;
  assign lane_eq_level      = r_reg.eq;
  assign lane_enable        = r_reg.lane_en;

  // ********************
  // Assertions
  // ********************
  property p_gen_top_zero;
    @(posedge mclk) disable iff (!rst_n)
    rd_byte[7:6] == 2'b00 || r_reg.ptr != ADDR_GEN;
  endproperty
  a_gen_top_zero: assert property (p_gen_top_zero) else $error("General reg top bits not zero");

  property p_force_high;
    @(posedge mclk) disable iff (!rst_n)
    r_reg.gen[GEN_FORCE_BIT] |=> hotplug_status;
  endproperty
  a_force_high: assert property (p_force_high) else $error("Hot-plug force ignored");

  property p_swap_pin;
    @(posedge mclk) disable iff (!rst_n)
    !r_reg.gen[GEN_FORCE_BIT] && r_reg.gen[GEN_SWAP_BIT] |=> hotplug_status == $past(hp_alt_s);
  endproperty
  a_swap_pin: assert property (p_swap_pin) else $error("Hot-plug swap pin wrong");

  property p_strap_eq;
    @(posedge mclk) disable iff (!rst_n)
    !r_reg.gen[GEN_EQSRC_BIT] |=> lane_eq_level == {4{$past(strap_level)}};
  endproperty
  a_strap_eq: assert property (p_strap_eq) else $error("EQ not following straps");

  property p_pwr_capture;
    @(posedge mclk) disable iff (!rst_n)
    aux_wr_valid && aux_wr_addr == AUX_PWR_ADDR |=> r_reg.pwr == $past(aux_wr_data[1:0]);
  endproperty
  a_pwr_capture: assert property (p_pwr_capture) else $error("Power state not captured");

  property p_cfg_fall_clear;
    @(posedge mclk) disable iff (!rst_n)
    r_reg.gen[GEN_CFG_HI_BIT] && !r_next.gen[GEN_CFG_HI_BIT] && !aux_wr_valid
    |=> r_reg.pwr == 2'b00 && r_reg.lcnt == 5'h00;
  endproperty
  a_cfg_fall_clear: assert property (p_cfg_fall_clear) else $error("Snoop fields not cleared");

  property p_snoop_lanes;
    @(posedge mclk) disable iff (!rst_n)
    !r_reg.snoop_dis ##1 !r_reg.snoop_dis |-> lane_enable == $past(snoop_mask);
  endproperty
  a_snoop_lanes: assert property (p_snoop_lanes) else $error("Snooped lane enables wrong");

  property p_off_bits;
    @(posedge mclk) disable iff (!rst_n)
    r_reg.snoop_dis |=> lane_enable == ~$past(r_reg.off);
  endproperty
  a_off_bits: assert property (p_off_bits) else $error("Lane off bits ignored");

  property p_no_drive_idle;
    @(posedge mclk) disable iff (!rst_n)
    r_reg.st == ST_IDLE |=> !sda_oe || $past(r_reg.st) != ST_IDLE;
  endproperty
  a_no_drive_idle: assert property (p_no_drive_idle) else $error("SDA driven while idle");

  property p_no_dp_lanes;
    @(posedge mclk) disable iff (!rst_n)
    !r_reg.snoop_dis && !r_reg.gen[GEN_CFG_HI_BIT] |=> lane_enable == 4'h0;
  endproperty
  a_no_dp_lanes: assert property (p_no_dp_lanes) else $error("DP lanes on in off or USB config");

endmodule

// ### ams_host.sv
// I2C host model that configures the mode switch register bank.
// Assumes the bench resolves SDA with a pull-up from both enables.
`timescale 1ns/1ns
module ams_host (
  // Clock
  input  wire logic mclk,
  // I2C wire
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  // ********************
  // Bus timing
  // ********************
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Quarter of a 160 ns SCL period; SCL stands high between frames
  task automatic q();
    repeat (4) @(posedge mclk);
    #1;
  endtask

  task automatic start();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
  endtask

  task automatic stop();
    // SDA must not move in the same instant as the SCL fall
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask

  // Data moves mid-low, sampled at the end of SCL high
  task automatic bit_x(input logic b, output logic r);
    q();
    sda_low = ~b;
    q();
    scl = 1'b1;
    q();
    q();
    r = sda_line;
    scl = 1'b0;
  endtask

  // ********************
  // Byte transfer
  // ********************
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r[i]);
    bit_x(last, a);  // ACK keeps a read going, NACK ends it
    ack = ~a;
  endtask
endmodule

// ### alt_mode_switch_ctrl_regs_tb.sv
// Self-checking bench of the mode switch register bank.
// Assumes the I2C host model and a pull-up on SDA.
`timescale 1ns/1ns
`define CHK(nm, e, g) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
    end \
  end
module alt_mode_switch_ctrl_regs_tb;
  import ams_pkg::*;
  // ********************
  // Signals
  // ********************
  logic        mclk, rst_n, scl, sda_low, sda_out, sda_oe, hp_pin, hp_alt, aux_v;
  logic        orient, hp_stat;
  logic [1:0]  straps, cfg_out;
  logic [19:0] aux_a;
  logic [7:0]  aux_d;
  logic [15:0] eq_out, v;
  logic [3:0]  lane_en, m;
  logic [4:0]  cnt;
  int          n_fail, n_tests;
  string       nm_q[$];
  logic [15:0] exp_q[$];
  logic [15:0] obs_q[$];
  wire         sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_low;

  ams_host host (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  ams_ctrl_regs DUT (.mclk(mclk), .rst_n(rst_n), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .hotplug_input_pin(hp_pin), .hotplug_input_alt_pin(hp_alt),
    .display_eq_straps(straps), .aux_wr_valid(aux_v), .aux_wr_addr(aux_a), .aux_wr_data(aux_d),
    .lane_config_select(cfg_out), .orientation_select(orient), .hotplug_status(hp_stat),
    .lane_eq_level(eq_out), .lane_enable(lane_en));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ********************
  // Tasks
  // ********************
  task automatic note(input string nm, input logic [15:0] e);
    nm_q.push_back(nm);
    exp_q.push_back(e);
  endtask

  task automatic look(input string nm, input logic [15:0] e, input logic [15:0] g);
    note(nm, e);
    obs_q.push_back(g);
  endtask

  task automatic wreg(input logic [7:0] sub, input int n, input logic [15:0] d);
    logic [7:0] r;
    logic       a;
    host.start();
    host.xfer({I2C_ADDR_DEF, 1'b0}, 1'b1, r, a);
    look("addr_ack", 16'h0001, {15'h0000, a});
    host.xfer(sub, 1'b1, r, a);
    for (int i = 0; i < n; i++)
      host.xfer(d[8*i +: 8], 1'b1, r, a);
    host.stop();
    repeat (4) @(posedge mclk);
    #1;
  endtask

  task automatic rcont(input int n, input logic [31:0] e);
    logic [7:0] r;
    logic       a;
    host.start();
    host.xfer({I2C_ADDR_DEF, 1'b1}, 1'b1, r, a);
    for (int i = 0; i < n; i++)
    begin
      host.xfer(8'hff, i == n - 1, r, a);
      look("read", {8'h00, e[8*i +: 8]}, {8'h00, r});
    end
    host.stop();
  endtask

  task automatic rreg(input logic [7:0] sub, input int n, input logic [31:0] e);
    wreg(sub, 0, 16'h0000);
    rcont(n, e);
  endtask

  task automatic aux(input logic [19:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    aux_v = 1'b1;
    aux_a = a;
    aux_d = d;
    @(posedge mclk);
    #1;
    aux_v = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  function automatic logic [3:0] lanes(input logic [1:0] c, input logic [4:0] k);
    logic [3:0] cm;
    cm = (c == CFG_DP4) ? 4'hf : (c == CFG_DP2_USB) ? 4'h3 : 4'h0;
    return cm & {k >= 4, k >= 4, k >= 2, k >= 1};
  endfunction

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ********************
  // Result watcher and timeout
  // ********************
  initial
  begin
    string       n;
    logic [15:0] e, g;
    forever
    begin
      @(negedge mclk);
      while (obs_q.size() > 0)
      begin
        n = nm_q.pop_front();
        e = exp_q.pop_front();
        g = obs_q.pop_front();
        `CHK(n, e, g)
      end
    end
  end

  initial
  begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end

  // ********************
  // Scenarios
  // ********************
  initial
  begin
    logic [7:0] r8;
    logic       a1;
    void'($urandom(32'h2183_f967));
    n_fail = 0;
    n_tests = 0;
    rst_n = 1'b0;
    aux_v = 1'b0;
    aux_a = 20'h0_0000;
    aux_d = 8'h00;
    // Nonzero straps and opposite pins so every check can trip
    straps = 2'($urandom_range(1, 3));
    hp_pin = 1'b1;
    hp_alt = 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    look("cfg", {14'h0000, CFG_USB}, {14'h0000, cfg_out});
    rreg(ADDR_GEN, 1, 32'h0000_0001);
    rreg(ADDR_EQ01, 2, {16'h0000, {4{straps, 2'b00}}});
    rcont(2, 32'h0000_0000);
    host.start();
    host.xfer({~I2C_ADDR_DEF, 1'b0}, 1'b1, r8, a1);
    host.stop();
    look("addr_nack", 16'h0000, {15'h0000, a1});
    wreg(ADDR_GEN, 1, 16'h00ff);
    rreg(ADDR_GEN, 1, 32'h0000_003f);
    look("cfg", 16'h0003, {14'h0000, cfg_out});
    look("orient", 16'h0001, {15'h0000, orient});
    look("hp_force", 16'h0001, {15'h0000, hp_stat});
    v = 16'($urandom);
    wreg(ADDR_EQ01, 2, v);
    look("eq_out", v, eq_out);
    rreg(ADDR_EQ01, 2, {16'h0000, v});
    wreg(ADDR_GEN, 1, 16'h0022);
    look("hp_swap", {15'h0000, hp_alt}, {15'h0000, hp_stat});
    wreg(ADDR_GEN, 1, 16'h0002);
    look("hp_pin", {15'h0000, hp_pin}, {15'h0000, hp_stat});
    look("eq_strap", {4{straps, 2'b00}}, eq_out);
    for (int c = 0; c < 4; c++)
    begin
      cnt = 5'(1 << $urandom_range(0, 2));
      wreg(ADDR_GEN, 1, 16'(c));
      aux(AUX_PWR_ADDR, {6'h00, PWR_ON});
      aux(AUX_CNT_ADDR, {3'h0, cnt});
      look("lanes", {12'h000, lanes(2'(c), cnt)}, {12'h000, lane_en});
    end
    aux(AUX_PWR_ADDR, 8'hfe);
    look("lanes_off", 16'h0000, {12'h000, lane_en});
    wreg(ADDR_SNOOP, 1, 16'h00ff);
    rreg(ADDR_SNOOP, 1, {24'h00_0000, 1'b0, 2'b10, cnt});
    wreg(ADDR_GEN, 1, 16'h0001);
    rreg(ADDR_SNOOP, 1, 32'h0000_0000);
    m = 4'($urandom_range(0, 14));
    wreg(ADDR_LANE_OFF, 1, {8'h00, 4'h8, m});
    look("lanes_sw", {12'h000, ~m}, {12'h000, lane_en});
    wreg(ADDR_LANE_OFF, 1, {12'h000, m});
    look("lanes_snoop", 16'h0000, {12'h000, lane_en});
    // Second reset in mid-run, bus idle
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    look("cfg_rst", {14'h0000, CFG_USB}, {14'h0000, cfg_out});
    look("orient_rst", 16'h0000, {15'h0000, orient});
    look("lanes_rst", 16'h0000, {12'h000, lane_en});
    rreg(ADDR_LANE_OFF, 1, 32'h0000_0000);
    #100;
    if (exp_q.size() != 0)
      n_fail++;
    give_verdict();
  end
endmodule
